/* File: sfp_addr_map.sv */
// splits an array address into sector, half block and block numbers
// assumes a 24-bit address in an 8 MB array; purely combinational
`timescale 1ns/10ps
`include "sfp_map.svh"

module sfp_addr_map (
    input wire logic [`SFP_ADDR_W-1:0] addr, // array address
    output logic [`SFP_SECTOR_W-1:0] sectorIdx, // 4 KB sector number
    output logic [`SFP_HALF_W-1:0] halfIdx, // 32 KB half block number
    output logic [`SFP_BLOCK_W-1:0] blockIdx // 64 KB block number
);
    // bits above the 8 MB space are ignored so the map wraps
    assign sectorIdx = addr[`SFP_ADDR_MSB:`SFP_SECTOR_LSB];
    assign halfIdx = addr[`SFP_ADDR_MSB:`SFP_HALF_LSB];
    assign blockIdx = addr[`SFP_ADDR_MSB:`SFP_BLOCK_LSB];

endmodule : sfp_addr_map

/* File: sfp_fifo.sv */
// small queue of received words; stream interface in, plain ports out
// assumes one clock and synchronous active-low reset
`timescale 1ns/10ps

module sfp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic mclk, // clock
    input wire logic rst_n, // sync reset
    sfp_stream_if.snk inS, // filling side
    output logic [WIDTH-1:0] outData, // head word
    output logic outValid, // head valid
    input wire logic outReady // drain accepts
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
            $error("sfp_fifo: depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrPtr_q;
    logic [AW:0] rdPtr_q;

    wire full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
    wire empty = (wrPtr_q == rdPtr_q);
    wire doWr = inS.valid && !full;
    wire doRd = outValid && outReady;

    assign inS.ready = !full;
    assign outValid = !empty;
    assign outData = mem[rdPtr_q[AW-1:0]];

    always_ff @(posedge mclk) begin
        if (doWr) mem[wrPtr_q[AW-1:0]] <= inS.data;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (doWr) wrPtr_q <= wrPtr_q + 1'b1;
            if (doRd) rdPtr_q <= rdPtr_q + 1'b1;
        end
    end

endmodule : sfp_fifo

/* File: sfp_host.sv */
// host model of the serial flash pins: select, serial clock and lane drivers
// assumes the bench resolves lane levels and returns them on laneSeen
`timescale 1ns/10ps

module sfp_host (
    input wire logic mclk, // bench clock
    input wire logic [3:0] laneSeen, // resolved lane levels
    output logic csN, // select, active low
    output logic sclkPin, // serial clock
    output logic [3:0] drv, // host lane values
    output logic [3:0] drvOe // host lane enables
);
    logic cpol = 1'b0; // clock idle level, mode 0 or 3
    initial begin
        csN = 1'b1;
        sclkPin = 1'b0;
        drv = 4'h0;
        drvOe = 4'h0;
    end
////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    // high first so the device sees a true falling edge
    task automatic sel();
        @(posedge mclk);
        csN <= 1'b1;
        sclkPin <= cpol;
        tick(4);
        csN <= 1'b0;
        tick(6);
    endtask : sel
    task automatic desel();
        tick(4);
        csN <= 1'b1;
        tick(4);
    endtask : desel
    // nb bits MSB first, step lanes a clock; data moves only while the clock is low
    task automatic xfer(input logic [7:0] txb, input int step, input int nb,
                        input logic rd, output logic [7:0] rxb);
        logic [3:0] m;
        m = 4'((1 << step) - 1);
        @(posedge mclk);
        for (int b = nb; b > 0; b -= step) begin
            sclkPin <= 1'b0;
            drv <= (drv & ~m) | (4'(txb >> (b - step)) & m);
            drvOe <= rd ? drvOe & ~m : drvOe | m;
            tick(4);
            sclkPin <= 1'b1;
            rxb = (rxb << step) | 8'(step == 1 ? {3'h0, laneSeen[1]} : laneSeen & m);
            tick(4);
        end
        sclkPin <= cpol;
        drvOe <= drvOe & ~m;
        tick(4);
    endtask : xfer
endmodule : sfp_host

/* File: sfp_map.svh */
// constants of the serial flash pin front end: address map fields, stream sizes
// assumes inclusion by bare name from every file that needs one of them
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH

// 24-bit array address, 8 MB space
`define SFP_ADDR_W 24
`define SFP_ADDR_MSB 22
// sector 4 KB, half block 32 KB, block 64 KB
`define SFP_SECTOR_LSB 12
`define SFP_HALF_LSB 15
`define SFP_BLOCK_LSB 16
`define SFP_SECTOR_W 11
`define SFP_HALF_W 8
`define SFP_BLOCK_W 7
// received data words and their queue
`define SFP_BYTE_W 8
`define SFP_FIFO_DEPTH 4
// pin synchroniser order inside the sampled vector
`define SFP_PIN_CS 5
`define SFP_PIN_SCLK 4
`define SFP_WP_LANE 2
`define SFP_HOLD_LANE 3
// lane masks for the three transfer widths
`define SFP_MASK_SINGLE 4'h2
`define SFP_MASK_DUAL 4'h3
`define SFP_MASK_QUAD 4'hf

`endif

/* File: sfp_pin_front.sv */
// pin front end of a serial flash: select, power modes, lane sampling and drive,
// hold, hardware write protect and address map outputs
// assumes the instruction decoder outside sets laneMode and txPhase on mclk
`timescale 1ns/10ps
`include "sfp_map.svh"

// What this block does
// - select high: deselected, pins other than write protect ignored, every lane output enable off.
// - deselected and no internal operation running: standby mode.
// - select low enables the device and enters active mode.
// - nothing accepted until a select falling edge is seen after reset.
// - incoming bits are sampled on serial clock rising edges.
// - lane outputs change only after serial clock falling edges.
// - dual and quad widths turn lanes 0 and 1 bidirectional.
// - write-protect low with lock bits 0/1 rejects status writes.
// - same protection keeps the selected array region locked.
// - four-lane enable drops write protect; pin becomes lane 2.
// - hold works only without four-lane enable; else lane 3.
// - hold pauses the link only; internal operations continue.
// - hold enters on hold low while serial clock is low.
// - hold leaves on hold high while serial clock is low.
// - array is uniform 4 KB aligned sectors from address zero.
// - eight sectors form a half block, two form a 64 KB block.
// - 128 blocks and 2048 sectors fill the 8 MB space.
// - in hold the lanes float and clock and input are ignored.
// - deselect during hold resets the link state.
// - works with the serial clock idling low or high.
module sfp_pin_front #(
    parameter int DEPTH = `SFP_FIFO_DEPTH
) (
    input wire logic mclk, // 10 MHz system clock
    input wire logic rst_n, // sync reset, active low
    input wire logic csN, // chip select pin, active low
    input wire logic sclkPin, // serial clock pin
    input wire logic [3:0] laneLineIn, // lane0..3 pin levels
    output logic [3:0] laneLineOut, // lane0..3 drive values
    output logic [3:0] laneLineOe, // lane0..3 drive enables, high drives
    input wire sfp_pkg::sfp_lane_mode_e laneMode, // width of current phase
    input wire logic txPhase, // decoder: device drives read data
    input wire logic [`SFP_BYTE_W-1:0] txData, // next byte to send
    output logic txTake, // pulse: txData loaded
    output logic [`SFP_BYTE_W-1:0] rxData, // received byte
    output logic rxValid, // received byte valid
    input wire logic rxReady, // consumer takes byte
    output logic rxOverrun, // sticky: byte lost, cleared by select
    input wire logic busyOp, // internal program/erase/status write
    input wire logic srLockUpper, // status lock bit, upper
    input wire logic srLockLower, // status lock bit, lower
    input wire logic fourLaneEnable, // quad enable bit
    input wire logic regionProtected, // opAddr inside protected region
    input wire logic [`SFP_ADDR_W-1:0] opAddr, // address under operation
    output logic activeMode, // selected, active power
    output logic standby, // standby power
    output logic holdActive, // link paused
    output logic srWriteBlock, // status writes rejected
    output logic arrayLocked, // opAddr hardware locked
    output logic [`SFP_SECTOR_W-1:0] sectorIdx, // sector of opAddr
    output logic [`SFP_HALF_W-1:0] halfIdx, // half block of opAddr
    output logic [`SFP_BLOCK_W-1:0] blockIdx // block of opAddr
);
    initial begin
        if (DEPTH < 2) $error("sfp_pin_front: queue depth below 2");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the first stage feeds only the second

    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic csPrev_q;
    logic sclkPrev_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            // select stages reset low: a select held low through reset is no edge
            sync1_q <= 6'h0f;
            sync2_q <= 6'h0f;
            csPrev_q <= 1'b0;
            sclkPrev_q <= 1'b0;
        end else begin
            sync1_q <= {csN, sclkPin, laneLineIn};
            sync2_q <= sync1_q;
            csPrev_q <= sync2_q[`SFP_PIN_CS];
            sclkPrev_q <= sync2_q[`SFP_PIN_SCLK];
        end
    end

    wire csHigh = sync2_q[`SFP_PIN_CS];
    wire sclkLvl = sync2_q[`SFP_PIN_SCLK];
    wire [3:0] laneS = sync2_q[3:0];
    wire csFall = !csHigh && csPrev_q;
    // edges only, so either idle level of the clock is fine
    wire sclkRise = sclkLvl && !sclkPrev_q;
    wire sclkFall = !sclkLvl && sclkPrev_q;

    ////////////////////////////////////////////////////////////////////////////
    // select, power-up arming, hold state

    logic armed_q;
    sfp_pkg::sfp_link_state_e state_q;
    sfp_pkg::sfp_link_state_e state_d;

    // select counts only once a falling edge has been seen since reset
    wire selNow = !csHigh && (armed_q || csFall);
    // hold pin means hold only without four-lane enable
    wire holdReq = !fourLaneEnable && !laneS[`SFP_HOLD_LANE];
    wire inSel = (state_q == sfp_pkg::LNK_SEL);

    always_comb begin
        state_d = state_q;
        case (state_q)
            sfp_pkg::LNK_OFF: begin
                if (selNow) state_d = sfp_pkg::LNK_SEL;
            end
            sfp_pkg::LNK_SEL: begin
                if (!selNow) state_d = sfp_pkg::LNK_OFF;
                else if (holdReq && !sclkLvl) state_d = sfp_pkg::LNK_HOLD;
            end
            sfp_pkg::LNK_HOLD: begin
                if (!selNow) state_d = sfp_pkg::LNK_OFF;
                else if (!holdReq && !sclkLvl) state_d = sfp_pkg::LNK_SEL;
            end
            default: state_d = sfp_pkg::LNK_OFF;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            state_q <= sfp_pkg::LNK_OFF;
        end else begin
            if (csFall) armed_q <= 1'b1;
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive: bits in on rising edges, bytes into the queue

    logic [`SFP_BYTE_W-1:0] rxShift_q;
    logic [2:0] rxCnt_q;
    logic pendValid_q;
    logic [`SFP_BYTE_W-1:0] pendData_q;

    wire [3:0] step = sfp_pkg::sfp_step(laneMode);
    wire [3:0] rxSum = {1'b0, rxCnt_q} + step;
    // edges count only in the selected, non-hold state
    wire rxTake = inSel && sclkRise;
    wire [`SFP_BYTE_W-1:0] rxNext =
        (laneMode == sfp_pkg::LANE_QUAD) ? {rxShift_q[3:0], laneS} :
        (laneMode == sfp_pkg::LANE_DUAL) ? {rxShift_q[5:0], laneS[1:0]} :
        {rxShift_q[6:0], laneS[0]};
    wire byteDone = rxTake && rxSum[3];

    sfp_stream_if #(.WIDTH(`SFP_BYTE_W)) wrS ();
    assign wrS.data = pendData_q;
    assign wrS.valid = pendValid_q;
    wire pushed = pendValid_q && wrS.ready;

    always_ff @(posedge mclk) begin
        if (!rst_n || !inSel && state_q != sfp_pkg::LNK_HOLD) begin
            // deselect aborts a partial byte
            rxShift_q <= '0;
            rxCnt_q <= '0;
        end else if (rxTake) begin
            rxShift_q <= rxNext;
            rxCnt_q <= rxSum[2:0];
        end
    end

    // one-word holding stage; a full queue stalls it, a new byte then overwrites the held one
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pendValid_q <= 1'b0;
            pendData_q <= '0;
            rxOverrun <= 1'b0;
        end else begin
            if (byteDone) begin
                pendValid_q <= 1'b1;
                pendData_q <= rxNext;
            end else if (pushed) begin
                pendValid_q <= 1'b0;
            end
            // a loss in the clearing cycle still sets the flag
            if (byteDone && pendValid_q && !wrS.ready) rxOverrun <= 1'b1;
            else if (csFall) rxOverrun <= 1'b0;
        end
    end

    sfp_fifo #(.WIDTH(`SFP_BYTE_W), .DEPTH(DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_n),
        .inS(wrS),
        .outData(rxData),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    ////////////////////////////////////////////////////////////////////////////
    // transmit: lanes change right after falling edges

    logic [`SFP_BYTE_W-1:0] txShift_q;
    logic [2:0] txCnt_q;

    wire txEdge = inSel && txPhase && sclkFall;
    wire txLoad = (txCnt_q == 3'h0);
    wire [`SFP_BYTE_W-1:0] txBits = txLoad ? txData : txShift_q;
    wire [3:0] txSum = {1'b0, txCnt_q} + step;
    wire [3:0] laneMask = sfp_pkg::sfp_mask(laneMode, fourLaneEnable);
    wire [3:0] driveVal =
        (laneMode == sfp_pkg::LANE_QUAD) ? txBits[7:4] :
        (laneMode == sfp_pkg::LANE_DUAL) ? {2'b00, txBits[7:6]} :
        {2'b00, txBits[7], 1'b0};
    // drivers only in the selected state, never in hold or deselect
    wire [3:0] oeNext = (inSel && state_d == sfp_pkg::LNK_SEL && txPhase) ? laneMask : 4'h0;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            txShift_q <= '0;
            txCnt_q <= '0;
            txTake <= 1'b0;
            laneLineOut <= 4'h0;
            laneLineOe <= 4'h0;
        end else begin
            txTake <= txEdge && txLoad;
            laneLineOe <= oeNext;
            if (state_q == sfp_pkg::LNK_OFF) begin
                txCnt_q <= '0;
            end else if (txEdge) begin
                laneLineOut <= driveVal & laneMask;
                txShift_q <= txBits << step;
                txCnt_q <= txSum[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power, protection and address map outputs

    // four-lane enable turns the write-protect pin into lane 2
    wire hwLock = !fourLaneEnable && !laneS[`SFP_WP_LANE]
        && !srLockUpper && srLockLower;
    wire [`SFP_SECTOR_W-1:0] sectorW;
    wire [`SFP_HALF_W-1:0] halfW;
    wire [`SFP_BLOCK_W-1:0] blkW;

    sfp_addr_map u_map (
        .addr(opAddr),
        .sectorIdx(sectorW),
        .halfIdx(halfW),
        .blockIdx(blkW)
    );

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            activeMode <= 1'b0;
            standby <= 1'b1;
            holdActive <= 1'b0;
            srWriteBlock <= 1'b0;
            arrayLocked <= 1'b0;
            sectorIdx <= '0;
            halfIdx <= '0;
            blockIdx <= '0;
        end else begin
            activeMode <= selNow;
            // busyOp is untouched by hold and keeps standby off
            standby <= !selNow && !busyOp;
            holdActive <= (state_d == sfp_pkg::LNK_HOLD);
            srWriteBlock <= hwLock;
            arrayLocked <= hwLock && regionProtected;
            sectorIdx <= sectorW;
            halfIdx <= halfW;
            blockIdx <= blkW;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence holdEnter;
        inSel && selNow && holdReq && !sclkLvl;
    endsequence
    sequence holdLeave;
        (state_q == sfp_pkg::LNK_HOLD) && selNow && !holdReq && !sclkLvl;
    endsequence

    chk_desel_no_drive: assert property (csHigh |=> laneLineOe == 4'h0)
        else $error("lane driven while deselected");
    chk_standby_power: assert property ((!selNow && !busyOp) |=> standby && !activeMode)
        else $error("standby not entered");
    chk_busy_no_standby: assert property (busyOp |=> !standby)
        else $error("standby during internal operation");
    chk_select_active: assert property (selNow |=> activeMode && state_q != sfp_pkg::LNK_OFF)
        else $error("select did not enable device");
    chk_powerup_arm: assert property (!armed_q && !csFall |=> state_q == sfp_pkg::LNK_OFF)
        else $error("selected before first select edge");
    chk_rise_sample: assert property ($rose(pendValid_q) |-> $past(sclkRise) && $past(inSel))
        else $error("byte completed without rising edge");
    chk_fall_drive: assert property ($changed(laneLineOut) |-> $past(sclkFall))
        else $error("lane output changed off a falling edge");
    chk_wp_reject: assert property ((hwLock && !fourLaneEnable) |=> srWriteBlock)
        else $error("status write not blocked");
    chk_quad_no_wp: assert property (fourLaneEnable |=> !srWriteBlock && !arrayLocked)
        else $error("write protect active in four-lane use");
    chk_quad_no_hold: assert property (
        (fourLaneEnable && state_q != sfp_pkg::LNK_HOLD) |=> state_q != sfp_pkg::LNK_HOLD)
        else $error("hold entered with four-lane enable");
    chk_hold_entry: assert property (holdEnter |=> state_q == sfp_pkg::LNK_HOLD && holdActive)
        else $error("hold not entered with clock low");
    chk_hold_exit: assert property (holdLeave |=> state_q == sfp_pkg::LNK_SEL)
        else $error("hold not left with clock low");
    chk_hold_float: assert property (state_q == sfp_pkg::LNK_HOLD |=> laneLineOe == 4'h0)
        else $error("lane driven during hold");
    chk_hold_abort: assert property (
        (state_q == sfp_pkg::LNK_HOLD && !selNow) |=> state_q == sfp_pkg::LNK_OFF ##1 rxCnt_q == 3'h0)
        else $error("deselect in hold did not reset link");

endmodule : sfp_pin_front

/* File: sfp_pkg.sv */
// types and small helpers of the serial flash pin front end
// assumes sfp_map.svh for lane masks
`include "sfp_map.svh"

package sfp_pkg;

    typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} sfp_lane_mode_e;
    typedef enum logic [1:0] {LNK_OFF, LNK_SEL, LNK_HOLD} sfp_link_state_e;

    // bits moved per clock edge for a transfer width
    function automatic logic [3:0] sfp_step(input sfp_lane_mode_e mode);
        case (mode)
            LANE_DUAL: sfp_step = 4'h2;
            LANE_QUAD: sfp_step = 4'h4;
            default: sfp_step = 4'h1;
        endcase
    endfunction : sfp_step

    // lanes that carry data for a width; quad needs the four-lane enable
    function automatic logic [3:0] sfp_mask(input sfp_lane_mode_e mode, input logic fourLane);
        case (mode)
            LANE_DUAL: sfp_mask = `SFP_MASK_DUAL;
            LANE_QUAD: sfp_mask = fourLane ? `SFP_MASK_QUAD : `SFP_MASK_DUAL;
            default: sfp_mask = `SFP_MASK_SINGLE;
        endcase
    endfunction : sfp_mask

endpackage : sfp_pkg

/* File: sfp_stream_if.sv */
// byte stream with valid and ready between front end and its queue
// assumes both ends on the same clock
`timescale 1ns/10ps

interface sfp_stream_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : sfp_stream_if

/* File: testbench.sv */
// self-checking bench of the serial flash pin front end driven by a host model
// assumes the design files and sfp_host are compiled first
`timescale 1ns/10ps
`include "sfp_map.svh"

module testbench;
    localparam int D = `SFP_FIFO_DEPTH;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic flip = 1'b0;
    logic txPhase = 1'b0, rxReady = 1'b0, busyOp = 1'b0, srLockUpper = 1'b0;
    logic srLockLower = 1'b0, fourLaneEnable = 1'b0, regionProtected = 1'b0;
    logic [7:0] txData = 8'h00;
    logic [23:0] opAddr = 24'h000000;
    sfp_pkg::sfp_lane_mode_e laneMode = sfp_pkg::LANE_SINGLE;
    logic csN, sclkPin, txTake, rxValid, rxOverrun, activeMode, standby, holdActive;
    logic srWriteBlock, arrayLocked;
    logic [3:0] hDrv, hOe, seen, dOut, dOe;
    logic [7:0] rxData, b;
    logic [`SFP_SECTOR_W-1:0] sectorIdx;
    logic [`SFP_HALF_W-1:0] halfIdx;
    logic [`SFP_BLOCK_W-1:0] blockIdx;
    logic [23:0] addrs [6] = '{24'h000fff, 24'h007000, 24'h008000, 24'h010000,
                               24'h7e8000, 24'h7fffff};
    int nMismatch = 0, checked = 0, takes = 0, cyc = 0;
    always #50 mclk = ~mclk;
    always @(posedge mclk) flip <= ~flip;
    // lanes 2 and 3 have pull-ups; released lanes 0 and 1 change every cycle
    assign seen = (dOe & dOut) | (~dOe & hOe & hDrv) | (~dOe & ~hOe & {2'b11, flip, ~flip});
    sfp_host i_host (.mclk, .laneSeen(seen), .csN, .sclkPin, .drv(hDrv), .drvOe(hOe));
    sfp_pin_front #(.DEPTH(D)) i_dut (
        .mclk, .rst_n, .csN, .sclkPin, .laneLineIn(seen), .laneLineOut(dOut),
        .laneLineOe(dOe), .laneMode, .txPhase, .txData, .txTake, .rxData, .rxValid, .rxReady,
        .rxOverrun, .busyOp, .srLockUpper, .srLockLower, .fourLaneEnable, .regionProtected,
        .opAddr, .activeMode, .standby, .holdActive, .srWriteBlock, .arrayLocked, .sectorIdx,
        .halfIdx, .blockIdx
    );
////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_bit(input logic got, input logic exp);
        chk_val(24'(got), 24'(exp));
    endtask : chk_bit
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : wt
    task automatic rx_expect(input logic [7:0] exp);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (rxValid !== 1'b1 && n < 300);
        chk_val(24'(rxData), 24'(exp));
        @(posedge mclk);
        rxReady <= 1'b1;
        @(posedge mclk);
        rxReady <= 1'b0;
    endtask : rx_expect
    task automatic hold_pin(input logic v);
        @(posedge mclk);
        i_host.drv[3] <= v;
        i_host.drvOe[3] <= 1'b1;
        wt(6);
    endtask : hold_pin
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (txTake === 1'b1) begin
            takes <= takes + 1;
        end
        if (cyc == 20000) begin
            nMismatch++;
            end_sim();
        end
    end
////////////////////////////////////////
    initial begin
        @(posedge mclk);
        i_host.csN <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wt(2);
        chk_bit(standby, 1'b1);
        chk_val(24'(dOe), 24'h0);
        // select held low through reset must not arm the device
        i_host.xfer(8'h5a, 1, 8, 1'b0, b);
        wt(4);
        chk_bit(activeMode, 1'b0);
        chk_bit(rxValid, 1'b0);
        i_host.sel();
        wt(1);
        chk_bit(activeMode, 1'b1);
        chk_bit(standby, 1'b0);
        for (int i = 0; i < D + 2; i++) begin
            i_host.xfer(8'h1f + 8'(i), 1, 8, 1'b0, b);
        end
        wt(4);
        chk_bit(rxOverrun, 1'b1);
        for (int i = 0; i <= D; i++) begin
            rx_expect(8'h1f + 8'(i == D ? i + 1 : i));
        end
        wt(2);
        chk_bit(rxValid, 1'b0);
        i_host.sel();
        wt(1);
        chk_bit(rxOverrun, 1'b0);
        @(posedge mclk);
        laneMode <= sfp_pkg::LANE_DUAL;
        i_host.xfer(8'h96, 2, 8, 1'b0, b);
        rx_expect(8'h96);
        @(posedge mclk);
        laneMode <= sfp_pkg::LANE_QUAD;
        fourLaneEnable <= 1'b1;
        i_host.xfer(8'h3c, 4, 8, 1'b0, b);
        rx_expect(8'h3c);
        @(posedge mclk);
        laneMode <= sfp_pkg::LANE_SINGLE;
        fourLaneEnable <= 1'b0;
        // pause mid-byte, clock junk while paused, leave late
        i_host.xfer(8'h0c, 1, 4, 1'b0, b);
        hold_pin(1'b0);
        chk_bit(holdActive, 1'b1);
        i_host.xfer(8'h0f, 1, 4, 1'b0, b);
        @(posedge mclk);
        i_host.sclkPin <= 1'b1;
        hold_pin(1'b1);
        chk_bit(holdActive, 1'b1);
        @(posedge mclk);
        i_host.sclkPin <= 1'b0;
        wt(6);
        chk_bit(holdActive, 1'b0);
        i_host.xfer(8'h09, 1, 4, 1'b0, b);
        rx_expect(8'hc9);
        i_host.xfer(8'h05, 1, 3, 1'b0, b);
        hold_pin(1'b0);
        i_host.desel();
        wt(1);
        chk_bit(holdActive, 1'b0);
        hold_pin(1'b1);
        i_host.sel();
        i_host.xfer(8'h77, 1, 8, 1'b0, b);
        rx_expect(8'h77);
        @(posedge mclk);
        fourLaneEnable <= 1'b1;
        hold_pin(1'b0);
        chk_bit(holdActive, 1'b0);
        hold_pin(1'b1);
        @(posedge mclk);
        fourLaneEnable <= 1'b0;
        txPhase <= 1'b1;
        txData <= 8'h6b;
        i_host.cpol = 1'b1;
        i_host.sel();
        i_host.xfer(8'h00, 1, 8, 1'b1, b);
        chk_val(24'(b), 24'h6b);
        wt(1);
        chk_val(24'(dOe), 24'h2);
        @(posedge mclk);
        laneMode <= sfp_pkg::LANE_QUAD;
        fourLaneEnable <= 1'b1;
        txData <= 8'hd2;
        i_host.xfer(8'h00, 4, 8, 1'b1, b);
        chk_val(24'(b), 24'hd2);
        wt(1);
        chk_val(24'(dOe), 24'hf);
        @(posedge mclk);
        fourLaneEnable <= 1'b0;
        wt(4);
        chk_val(24'(dOe), 24'h3);
        chk_val(24'(takes), 24'h2);
        i_host.desel();
        @(posedge mclk);
        busyOp <= 1'b1;
        wt(4);
        chk_val(24'(dOe), 24'h0);
        chk_bit(standby, 1'b0);
        @(posedge mclk);
        busyOp <= 1'b0;
        wt(3);
        chk_bit(standby, 1'b1);
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk);
            {fourLaneEnable, srLockUpper, srLockLower, regionProtected} <= 4'(i);
            i_host.drv[2] <= i[4];
            i_host.drvOe[2] <= 1'b1;
            wt(5);
            chk_bit(srWriteBlock, ~i[4] & ~i[3] & ~i[2] & i[1]);
            chk_bit(arrayLocked, ~i[4] & ~i[3] & ~i[2] & i[1] & i[0]);
        end
        foreach (addrs[k]) begin
            @(posedge mclk);
            opAddr <= addrs[k];
            wt(2);
            chk_val(24'(sectorIdx), 24'(addrs[k][22:12]));
            chk_val(24'(halfIdx), 24'(addrs[k][22:15]));
            chk_val(24'(blockIdx), 24'(addrs[k][22:16]));
        end
        chk_val(24'(sectorIdx), 24'h7ff);
        end_sim();
    end
endmodule : testbench
